// file: include/nqa_pkg.sv
// nqa_pkg: codes, field values, timing and message carriers for the node query / alert handler
// assumes messages arrive already parsed into fields and leave as fields for a framer
package nqa_pkg;
  // ==========================================================
  // message codes
  localparam logic [7:0]  NQA_CODE_QUERY    = 8'h00;
  localparam logic [7:0]  NQA_CODE_REPLY    = 8'h01;
  localparam logic [7:0]  NQA_CODE_ALERT    = 8'h05;
  localparam logic [7:0]  NQA_CODE_RESPONSE = 8'h0E;
  localparam logic [7:0]  NQA_RC_OK         = 8'h00;
  // ==========================================================
  // transport versions
  localparam logic [7:0]  NQA_VER_PRE       = 8'h00;
  localparam logic [7:0]  NQA_VER_STD1      = 8'h02;
  localparam logic [7:0]  NQA_VER_CUR       = 8'h10;
  // ==========================================================
  // upper level protocol codes
  localparam logic [7:0]  NQA_ULP_QUERY     = 8'h00;
  localparam logic [7:0]  NQA_ULP_NONE      = 8'h01;
  localparam logic [7:0]  NQA_ULP_VENDOR    = 8'h02;
  localparam logic [7:0]  NQA_ULP_P80       = 8'h80;
  localparam logic [7:0]  NQA_ULP_P82       = 8'h82;
  localparam logic [7:0]  NQA_ULP_P83       = 8'h83;
  // ==========================================================
  // alert codes that steer the handler
  localparam logic [23:0] NQA_ALERT_ERP_EXIT = 24'h000001;
  localparam logic [23:0] NQA_ALERT_NORMAL   = 24'h000002;
  localparam logic [7:0]  NQA_PATH_PAD       = 8'h00;
  // ==========================================================
  // timing
  localparam longint      NQA_MA_TIME_S     = 10;
  localparam longint      NQA_CLK_HZ        = 25000000;
  localparam int          NQA_MA_CYCLES     = int'(NQA_MA_TIME_S * NQA_CLK_HZ);
  localparam logic [7:0]  NQA_RST_PORT      = 8'h00;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  rx_port;
    logic [7:0]  port;
    logic [15:0] tag;
    logic [31:0] ret_path;
    logic [63:0] node_id;
    logic [7:0]  version;
    logic        registration_disable;
    logic        master_alive_flag;
    logic [23:0] alert_code;
    logic [7:0]  control;
    logic [15:0] channel;
    logic [15:0] frame_data;
  } nqa_rx_s;

  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  tx_port;
    logic [31:0] addr_path;
    logic [2:0]  addr_len;
    logic [7:0]  port;
    logic [15:0] tag;
    logic [7:0]  ret_code;
    logic [7:0]  ulp;
    logic [2:0]  master_priority;
    logic [7:0]  other_ports;
    logic [7:0]  version;
    logic [63:0] node_identifier;
    logic [31:0] reply_path_identifier;
    logic        port1_operational;
    logic        port2_operational;
    logic        long_distance;
    logic        table_full_flag;
  } nqa_tx_s;
endpackage

// file: rtl/nqa_handler.sv
// nqa_handler: takes node queries and forwarded alerts, keeps the configuring-node table, builds replies
// assumes parsed messages from a same-clock receiver and a same-clock framer draining tx
// How it works
// - master forwards alerts to other configuring nodes
// - link recovery exit alert: quiesce before responding
// - alert other than normal-mode invalidates affected nodes' configuration entries
// - normal-mode alert answered without waiting
// - response echoes the alert's tag
// - alert fields copied unchanged, two frame bytes; the response here carries none of them
// - response with same tag carries return code
// - node query code 00h, version 10h
// - reply highest supported version not above query
// - query return path stored, addresses reply
// - registration disable clear records path and identifier
// - master alive flag restarts ten second timer
// - reply 01h on receiving port, echoes tag
// - reply protocol byte holds an allowed code
// - table full flag when no free entry and no matching entry
// - master priority three bits, default four
// - other ports count is ports minus one
// - reply carries self generated path identifier
// - port operational bits; switches clear both
// - long bit when any port extended distance
// - reply address path from query, padding dropped
module nqa_handler
  import nqa_pkg::*;
#(
  parameter int          ENTRIES     = 4,
  parameter logic [2:0]  MASTER_PRI  = 3'd4,
  parameter logic [7:0]  OTHER_PORTS = 8'd1,
  parameter int          MA_CYCLES   = NQA_MA_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // received messages
  input  wire logic        rx_valid_i,
  output logic             rx_ready_o,
  input  wire nqa_rx_s     rx_msg_i,
  // transmitted messages
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  output nqa_tx_s          tx_msg_o,
  // node status
  input  wire logic [7:0]  ulp_code_i,
  input  wire logic [63:0] node_identifier_i,
  input  wire logic        port1_operational_i,
  input  wire logic        port2_operational_i,
  input  wire logic        long_distance_i,
  // i/o quiesce and configuration table
  output logic             quiesce_req_o,
  output logic [7:0]       quiesce_port_o,
  input  wire logic        quiesce_done_i,
  output logic             invalidate_o,
  output logic [63:0]      invalidate_node_o,
  // master alive timer
  output logic             master_alive_expired_o
);
  localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  // ==========================================================
  // parameter checks
  if (ENTRIES < 1) begin : g_chk_entries
    $error("ENTRIES must be at least one");
  end
  if (OTHER_PORTS > 8'd1 && OTHER_PORTS[0] == 1'b0) begin : g_chk_ports
    $error("OTHER_PORTS must be 0, 1 or odd");
  end
  if (MA_CYCLES < 1 || MA_CYCLES > 32'h0FFF_FFFF) begin : g_chk_ma
    $error("MA_CYCLES out of range");
  end

  // ==========================================================
  // helpers
  function automatic logic nqa_ulp_ok(input logic [7:0] c);
    return c == NQA_ULP_QUERY || c == NQA_ULP_NONE || c == NQA_ULP_VENDOR ||
           c == NQA_ULP_P80 || c == NQA_ULP_P82 || c == NQA_ULP_P83;
  endfunction

  function automatic logic [7:0] nqa_pick_ver(input logic [7:0] q);
    if (q >= NQA_VER_CUR) return NQA_VER_CUR;
    else if (q >= NQA_VER_STD1) return NQA_VER_STD1;
    else return NQA_VER_PRE;
  endfunction

  function automatic logic [2:0] nqa_path_len(input logic [31:0] p);
    logic [2:0] n;
    n = 3'd4;
    for (int b = 0; b < 4; b++) begin
      if (p[b*8 +: 8] == NQA_PATH_PAD) n = 3'(3 - b);
    end
    return n;
  endfunction

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_QUIESCE = 3'b010,
    ST_SEND    = 3'b100
  } nqa_state_e;

  nqa_state_e           state_r,   state_nxt;
  nqa_rx_s              msg_r,     msg_nxt;
  nqa_tx_s              tx_r,      tx_nxt;
  logic [ENTRIES-1:0]   tbl_vld_r, tbl_vld_nxt;
  logic [63:0]          tbl_id_r   [ENTRIES];
  logic [63:0]          tbl_id_nxt [ENTRIES];
  logic [31:0]          tbl_path_r   [ENTRIES];
  logic [31:0]          tbl_path_nxt [ENTRIES];
  logic [31:0]          pid_r,     pid_nxt;
  logic                 inval_r,   inval_nxt;
  logic [27:0]          ma_cnt_r,  ma_cnt_nxt;
  logic                 acc;
  logic                 hit;
  logic                 has_free;
  logic [IW-1:0]        free_idx;

  assign rx_ready_o = (state_r == ST_IDLE);
  assign acc        = rx_valid_i && rx_ready_o;

  // ==========================================================
  // table lookup
  always_comb begin
    hit      = 1'b0;
    has_free = 1'b0;
    free_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (!tbl_vld_r[i]) begin
        has_free = 1'b1;
        free_idx = IW'(i);
      end else if (tbl_id_r[i] == rx_msg_i.node_id && tbl_path_r[i] == rx_msg_i.ret_path) begin
        hit = 1'b1;
      end
    end
  end

  // ==========================================================
  // message handling
  always_comb begin
    state_nxt    = state_r;
    msg_nxt      = msg_r;
    tx_nxt       = tx_r;
    tbl_vld_nxt  = tbl_vld_r;
    tbl_id_nxt   = tbl_id_r;
    tbl_path_nxt = tbl_path_r;
    pid_nxt      = pid_r;
    inval_nxt    = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (acc && rx_msg_i.code == NQA_CODE_QUERY) begin
          msg_nxt = rx_msg_i;
          tx_nxt  = '0;
          if (!rx_msg_i.registration_disable && !hit && has_free) begin
            tbl_vld_nxt[free_idx]  = 1'b1;
            tbl_id_nxt[free_idx]   = rx_msg_i.node_id;
            tbl_path_nxt[free_idx] = rx_msg_i.ret_path;
          end
          tx_nxt.table_full_flag       = !hit && !has_free;
          tx_nxt.code                  = NQA_CODE_REPLY;
          tx_nxt.tx_port               = rx_msg_i.rx_port;
          tx_nxt.port                  = rx_msg_i.rx_port;
          tx_nxt.tag                   = rx_msg_i.tag;
          tx_nxt.addr_path             = rx_msg_i.ret_path;
          tx_nxt.addr_len              = nqa_path_len(rx_msg_i.ret_path);
          tx_nxt.ulp                   = nqa_ulp_ok(ulp_code_i) ? ulp_code_i : NQA_ULP_QUERY;
          tx_nxt.master_priority       = MASTER_PRI;
          tx_nxt.other_ports           = OTHER_PORTS;
          tx_nxt.version               = nqa_pick_ver(rx_msg_i.version);
          tx_nxt.node_identifier       = node_identifier_i;
          tx_nxt.reply_path_identifier = pid_r;
          pid_nxt                      = pid_r + 32'h0000_0001;
          tx_nxt.port1_operational     = (OTHER_PORTS <= 8'd1) && port1_operational_i;
          tx_nxt.port2_operational     = (OTHER_PORTS <= 8'd1) && port2_operational_i;
          tx_nxt.long_distance         = long_distance_i;
          state_nxt = ST_SEND;
        end else if (acc && rx_msg_i.code == NQA_CODE_ALERT) begin
          msg_nxt   = rx_msg_i;
          inval_nxt = (rx_msg_i.alert_code != NQA_ALERT_NORMAL);
          tx_nxt          = '0;
          tx_nxt.code     = NQA_CODE_RESPONSE;
          tx_nxt.tx_port  = rx_msg_i.rx_port;
          tx_nxt.port     = rx_msg_i.rx_port;
          tx_nxt.tag      = rx_msg_i.tag;
          tx_nxt.ret_code = NQA_RC_OK;
          tx_nxt.addr_path = rx_msg_i.ret_path;
          tx_nxt.addr_len  = nqa_path_len(rx_msg_i.ret_path);
          if (rx_msg_i.alert_code == NQA_ALERT_ERP_EXIT) begin
            state_nxt = ST_QUIESCE;
          end else begin
            state_nxt = ST_SEND;
          end
        end
      end
      ST_QUIESCE: begin
        if (quiesce_done_i) begin
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_ready_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r   <= ST_IDLE;
      msg_r     <= '0;
      tx_r      <= '0;
      tbl_vld_r <= '0;
      pid_r     <= '0;
      inval_r   <= 1'b0;
      for (int i = 0; i < ENTRIES; i++) begin
        tbl_id_r[i]   <= '0;
        tbl_path_r[i] <= '0;
      end
    end else begin
      state_r   <= state_nxt;
      msg_r     <= msg_nxt;
      tx_r      <= tx_nxt;
      tbl_vld_r <= tbl_vld_nxt;
      pid_r     <= pid_nxt;
      inval_r   <= inval_nxt;
      for (int i = 0; i < ENTRIES; i++) begin
        tbl_id_r[i]   <= tbl_id_nxt[i];
        tbl_path_r[i] <= tbl_path_nxt[i];
      end
    end
  end

  // ==========================================================
  // master alive timer
  always_comb begin
    ma_cnt_nxt = ma_cnt_r;
    if (acc && rx_msg_i.code == NQA_CODE_QUERY && rx_msg_i.master_alive_flag) begin
      ma_cnt_nxt = 28'(MA_CYCLES);
    end else if (ma_cnt_r != 28'h0) begin
      ma_cnt_nxt = ma_cnt_r - 28'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ma_cnt_r <= 28'(MA_CYCLES);
    end else begin
      ma_cnt_r <= ma_cnt_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign tx_valid_o             = (state_r == ST_SEND);
  assign tx_msg_o               = tx_r;
  assign quiesce_req_o          = (state_r == ST_QUIESCE);
  assign quiesce_port_o         = msg_r.port;
  assign invalidate_o           = inval_r;
  assign invalidate_node_o      = msg_r.node_id;
  assign master_alive_expired_o = (ma_cnt_r == 28'h0);

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  a_reply_port_tag: assert property (acc && rx_msg_i.code == NQA_CODE_QUERY |=> tx_valid_o &&
      tx_msg_o.code == NQA_CODE_REPLY && tx_msg_o.tx_port == $past(rx_msg_i.rx_port) &&
      tx_msg_o.tag == $past(rx_msg_i.tag))
    else $error("reply code, port or tag wrong");
  a_version_cap: assert property (tx_valid_o && tx_msg_o.code == NQA_CODE_REPLY |->
      tx_msg_o.version <= msg_r.version || tx_msg_o.version == NQA_VER_PRE)
    else $error("reply version above query");
  a_ulp_legal: assert property (tx_valid_o && tx_msg_o.code == NQA_CODE_REPLY |->
      nqa_ulp_ok(tx_msg_o.ulp))
    else $error("illegal protocol code");
  a_switch_ports: assert property (tx_valid_o && tx_msg_o.code == NQA_CODE_REPLY |->
      tx_msg_o.master_priority == MASTER_PRI && tx_msg_o.other_ports == OTHER_PORTS &&
      (OTHER_PORTS <= 8'd1 || !(tx_msg_o.port1_operational || tx_msg_o.port2_operational)))
    else $error("priority, port count or port bits wrong");
  a_path_copy: assert property (tx_valid_o && tx_msg_o.code == NQA_CODE_REPLY |->
      tx_msg_o.addr_path == msg_r.ret_path)
    else $error("reply path not from query");
  a_ma_restart: assert property (acc && rx_msg_i.code == NQA_CODE_QUERY && rx_msg_i.master_alive_flag
      |=> ma_cnt_r == 28'(MA_CYCLES) ##1 !master_alive_expired_o)
    else $error("master alive timer not restarted");
  a_normal_fast: assert property (acc && rx_msg_i.code == NQA_CODE_ALERT &&
      rx_msg_i.alert_code == NQA_ALERT_NORMAL |=> tx_valid_o && !invalidate_o)
    else $error("normal mode alert not answered at once");
  a_quiesce_first: assert property (quiesce_req_o && !quiesce_done_i |=> quiesce_req_o && !tx_valid_o)
    else $error("response before quiesce done");
  a_alert_inval: assert property (acc && rx_msg_i.code == NQA_CODE_ALERT &&
      rx_msg_i.alert_code != NQA_ALERT_NORMAL |=> invalidate_o &&
      invalidate_node_o == $past(rx_msg_i.node_id))
    else $error("alert did not invalidate");
  a_dr_hold: assert property (acc && rx_msg_i.code == NQA_CODE_QUERY && rx_msg_i.registration_disable
      |=> $stable(tbl_vld_r))
    else $error("table changed with registration disabled");
  a_resp_tag: assert property (tx_valid_o && tx_msg_o.code == NQA_CODE_RESPONSE |->
      tx_msg_o.tag == msg_r.tag && tx_msg_o.ret_code == NQA_RC_OK)
    else $error("response tag not echoed");
  a_table_record: assert property (acc && rx_msg_i.code == NQA_CODE_QUERY &&
      !rx_msg_i.registration_disable && !hit && has_free |=> tbl_vld_r[$past(free_idx)] &&
      tbl_path_r[$past(free_idx)] == $past(rx_msg_i.ret_path))
    else $error("query path not recorded");
  a_full_flag: assert property (acc && rx_msg_i.code == NQA_CODE_QUERY |=>
      tx_msg_o.table_full_flag == !($past(hit) || $past(has_free)))
    else $error("table full flag wrong");
  a_pid_step: assert property (acc && rx_msg_i.code == NQA_CODE_QUERY |=>
      tx_msg_o.reply_path_identifier == $past(pid_r) && pid_r == $past(pid_r) + 32'h0000_0001)
    else $error("reply path identifier not stepped");
  a_long_bit: assert property (acc && rx_msg_i.code == NQA_CODE_QUERY |=>
      tx_msg_o.long_distance == $past(long_distance_i) &&
      tx_msg_o.port1_operational == ((OTHER_PORTS <= 8'd1) && $past(port1_operational_i)))
    else $error("long or port bit wrong");
  a_resp_reserved: assert property (tx_valid_o && tx_msg_o.code == NQA_CODE_RESPONSE |->
      tx_msg_o.ulp == 8'h00 && tx_msg_o.node_identifier == 64'h0 && !tx_msg_o.table_full_flag &&
      tx_msg_o.reply_path_identifier == 32'h0)
    else $error("response reserved field not zero");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_msg_o))
    else $error("message dropped before taken");
  a_path_len: assert property (tx_valid_o |-> tx_msg_o.addr_len <= 3'h4)
    else $error("path length above four");
  a_inval_pulse: assert property (invalidate_o |=> !invalidate_o)
    else $error("invalidate longer than a cycle");
  a_ma_hold: assert property (master_alive_expired_o && !(acc && rx_msg_i.master_alive_flag &&
      rx_msg_i.code == NQA_CODE_QUERY) |=> master_alive_expired_o)
    else $error("expired timer left without restart");

  // ==========================================================
  // main scenarios
  c_query: cover property (acc && rx_msg_i.code == NQA_CODE_QUERY ##[1:8] tx_valid_o && tx_ready_i);
  c_erp_alert: cover property (quiesce_req_o ##1 quiesce_done_i ##1 tx_valid_o);
  c_table_full: cover property (tx_valid_o && tx_msg_o.table_full_flag);
  c_ma_expire: cover property ($rose(master_alive_expired_o));
  c_normal_alert: cover property (acc && rx_msg_i.code == NQA_CODE_ALERT && rx_msg_i.alert_code == NQA_ALERT_NORMAL);

endmodule // nqa_handler

// file: test/nqa_peer.sv
// nqa_peer: far-side node model that hands parsed messages in and drains the handler's answers
// assumes the handler's clock and reset; the bench calls send() and sets slow
module nqa_peer
  import nqa_pkg::*;
(
  // clock and reset
  input  wire logic    clk_sys_i,
  input  wire logic    rst_b_i,
  // toward the handler
  output logic         rx_valid_o,
  input  wire logic    rx_ready_i,
  output nqa_rx_s      rx_msg_o,
  // from the handler
  input  wire logic    tx_valid_i,
  output logic         tx_ready_o,
  input  wire nqa_tx_s tx_msg_i
);
  timeunit 1ns;
  timeprecision 1ns;
  bit slow;
  initial begin
    slow       = 1'b0;
    rx_valid_o = 1'b0;
    rx_msg_o   = '0;
    tx_ready_o = 1'b0;
  end
  // ==========================================================
  // one message in, at most one answer out
  task automatic send(input nqa_rx_s m, output nqa_tx_s r, output bit got);
    int n;
    got = 1'b0;
    r = '0;
    @(negedge clk_sys_i);
    rx_valid_o = 1'b1;
    rx_msg_o   = m;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (!rx_ready_i && n < 50);
    @(negedge clk_sys_i);
    rx_valid_o = 1'b0;
    rx_msg_o   = ~m;
    for (n = 0; n < 60 && !got; n++) begin
      @(negedge clk_sys_i);
      got = tx_valid_i;
    end
    if (got) begin
      if (slow) repeat (3) @(negedge clk_sys_i);
      r = tx_msg_i;
      tx_ready_o = 1'b1;
      @(negedge clk_sys_i);
      tx_ready_o = 1'b0;
    end
  endtask
endmodule // nqa_peer

// file: test/tb_top.sv
// tb_top: random and corner node queries and forwarded alerts against the handler
// assumes nqa_pkg, nqa_handler and nqa_peer are compiled first
module tb_top
  import nqa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] ACODES [3] = '{NQA_ALERT_ERP_EXIT, NQA_ALERT_NORMAL, 24'h000105};
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, qreq, inv, expired;
  nqa_rx_s     rx_msg;
  nqa_tx_s     tx_msg, r, e;
  logic [7:0]  ulp = 8'h00;
  logic [7:0]  qport;
  logic [63:0] nid = 64'h0;
  logic [63:0] inv_node;
  logic        p1 = 1'b0, p2 = 1'b0, ld = 1'b0, qdone = 1'b0;
  logic [7:0]  ulps [7] = '{8'h00, 8'h01, 8'h02, 8'h80, 8'h82, 8'h83, 8'h40};
  logic [7:0]  vers [6] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h10, 8'h20};
  logic [31:0] paths [2] = '{32'h0A0B0C0D, 32'h1234_0000};
  logic [95:0] tbl [$];
  int          num_errors = 0, checks = 0, seed = 58, cyc = 0, qcnt = 0, ninv = 0, pid = 0;
  bit          got, qseen;
  always #20 clk_sys_i = ~clk_sys_i;
  nqa_handler #(.MA_CYCLES(20)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
    .rx_msg_i(rx_msg), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_msg_o(tx_msg),
    .ulp_code_i(ulp), .node_identifier_i(nid), .port1_operational_i(p1), .port2_operational_i(p2),
    .long_distance_i(ld), .quiesce_req_o(qreq), .quiesce_port_o(qport), .quiesce_done_i(qdone),
    .invalidate_o(inv), .invalidate_node_o(inv_node), .master_alive_expired_o(expired));
  nqa_peer u_peer (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .rx_msg_o(rx_msg), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_msg_i(tx_msg));
  // ==========================================================
  // i/o quiesce finishes four cycles after the request
  always @(negedge clk_sys_i) begin
    qcnt = qreq ? qcnt + 1 : 0;
    qdone <= (qcnt >= 4);
    if (qreq) qseen = 1'b1;
  end
  always @(negedge clk_sys_i) begin
    cyc++;
    if (inv) ninv++;
    if (qreq) chk(tx_valid, 1'b0);
    if (cyc == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  // ==========================================================
  // compare and verdict
  task automatic chk(input logic [255:0] got_v, input logic [255:0] exp_v);
    checks++;
    if (got_v !== exp_v) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================================
  // expected reply
  function automatic nqa_tx_s exp_reply(nqa_rx_s m, logic full, int id);
    nqa_tx_s x;
    x = '0;
    x.code = NQA_CODE_REPLY;
    x.tx_port = m.rx_port;
    x.port = m.rx_port;
    x.tag = m.tag;
    x.addr_path = m.ret_path;
    for (int i = 3; i >= 0 && m.ret_path[i*8+:8] != 8'h00; i--) x.addr_len++;
    x.ulp = (ulp inside {8'h00, 8'h01, 8'h02, 8'h80, 8'h82, 8'h83}) ? ulp : 8'h00;
    x.master_priority = 3'h4;
    x.other_ports = 8'h01;
    x.version = (m.version >= 8'h10) ? 8'h10 : (m.version >= 8'h02) ? 8'h02 : 8'h00;
    x.node_identifier = nid;
    x.reply_path_identifier = 32'(id);
    x.port1_operational = p1;
    x.port2_operational = p2;
    x.long_distance = ld;
    x.table_full_flag = full;
    return x;
  endfunction
  task automatic query(input nqa_rx_s m);
    logic hit;
    logic full;
    hit = 1'b0;
    foreach (tbl[i]) if (tbl[i] == {m.node_id, m.ret_path}) hit = 1'b1;
    full = !hit && tbl.size() == 4;
    if (!hit && !full && !m.registration_disable) tbl.push_back({m.node_id, m.ret_path});
    e = exp_reply(m, full, pid);
    u_peer.send(m, r, got);
    pid++;
    chk(got, 1'b1);
    chk(r, e);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    nqa_rx_s m;
    repeat (10) @(negedge clk_sys_i);
    chk({rx_ready, tx_valid, qreq, inv, expired, tx_msg == '0}, 6'b100001);
    rst_b_i = 1'b1;
    repeat (25) @(negedge clk_sys_i);
    chk(expired, 1'b1);
    for (int k = 0; k < 24; k++) begin
      m = '0;
      m.code = NQA_CODE_QUERY;
      m.rx_port = 8'(1 + ($random(seed) & 1));
      m.tag = 16'(16'h0100 + k);
      m.ret_path = paths[$random(seed) & 1];
      m.node_id = 64'(16'h5000 + ($random(seed) & 7));
      m.version = vers[k % 6];
      m.registration_disable = (($random(seed) & 3) == 0);
      m.master_alive_flag = (k == 0);
      ulp = ulps[k % 7];
      nid = {32'($random(seed)), 32'($random(seed))};
      p1 = 1'($random(seed));
      p2 = 1'($random(seed));
      ld = 1'($random(seed));
      u_peer.slow = 1'($random(seed));
      query(m);
      if (k == 0) chk(expired, 1'b0);
    end
    chk(expired, 1'b1);
    foreach (ACODES[j]) begin
      m = '0;
      m.code = NQA_CODE_ALERT;
      m.rx_port = 8'h01;
      m.port = 8'(j + 2);
      m.tag = 16'(16'h0A00 + j);
      m.ret_path = paths[0];
      m.node_id = 64'(16'h7700 + j);
      m.alert_code = ACODES[j];
      m.control = 8'($random(seed));
      m.channel = 16'($random(seed));
      m.frame_data = 16'($random(seed));
      qseen = 1'b0;
      ninv = 0;
      u_peer.send(m, r, got);
      chk({got, r.code, r.tag, r.ret_code}, {1'b1, NQA_CODE_RESPONSE, m.tag, NQA_RC_OK});
      chk({r.tx_port, r.addr_path}, {m.rx_port, m.ret_path});
      chk({qseen, 8'(ninv)}, {1'(j == 0), 8'(j != 1)});
      if (j != 1) chk(inv_node, m.node_id);
      if (j == 0) chk(qport, m.port);
    end
    rst_b_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk({rx_ready, tx_valid, qreq, inv, expired, tx_msg == '0}, 6'b100001);
    rst_b_i = 1'b1;
    tbl.delete();
    pid = 0;
    m = '0;
    m.code = NQA_CODE_QUERY;
    m.rx_port = 8'h02;
    m.tag = 16'h0200;
    m.ret_path = paths[1];
    m.node_id = 64'h5000;
    m.version = 8'h10;
    query(m);
    chk(expired, 1'b0);
    print_verdict();
  end
endmodule // tb_top
